// *** src/scr_defines.svh ***
// Constants for the serial checksum and register map block
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Checksum generator x^8+x^2+x+1, top bit implied
`define SCR_CRC_POLY 8'h07
// All ones start is the same as inverting the top eight message bits
`define SCR_CRC_INIT 8'hff

// Register addresses
`define SCR_ADDR_SETUP1 3'h1
`define SCR_ADDR_SETUP2 3'h2
`define SCR_ADDR_FLAGS 3'h3
`define SCR_ADDR_LOWER 3'h4
`define SCR_ADDR_UPPER 3'h5

// Reset values of the stored fields
`define SCR_RST_SETUP1 10'h000
`define SCR_RST_SETUP2 9'h000
`define SCR_RST_LOWER 12'h800
`define SCR_RST_UPPER 12'h7ff

// First setup register fields
`define SCR_B_AVG_STYLE 9
`define SCR_B_RATIO_HI 8
`define SCR_B_RATIO_LO 6
`define SCR_B_CRC_W 5
`define SCR_B_CRC_R 4
`define SCR_B_ALERT_EN 3
`define SCR_B_EXT_RES 2
`define SCR_B_REF_SRC 1
`define SCR_B_PWR 0
`define SCR_RATIO_VALID_MAX 3'h5

// Second setup register fields
`define SCR_B_OUT_WIDTH 8
`define SCR_B_RSTCMD_HI 7

// Fault flag fields
`define SCR_B_CHK_FAIL 9
`define SCR_B_SELF_FAIL 8
`define SCR_B_B_OVER 5
`define SCR_B_B_UNDER 4
`define SCR_B_A_OVER 1
`define SCR_B_A_UNDER 0

// Command word layout
`define SCR_WR_BIT 15
`define SCR_ADDR_HI 14
`define SCR_ADDR_LO 12
`define SCR_DATA_HI 11

// Frame and message sizes
`define SCR_FRAME_PLAIN 6'd16
`define SCR_FRAME_CHECKED 6'd24
`define SCR_BOOST_BITS 2
`define SCR_MAX_CHAN_W 18
`define SCR_MSG_W 36
`define SCR_PRI_W 44
`define SCR_RX_W 24

`endif

// *** src/scr_pkg.sv ***
// Types shared by the serial checksum and register map block
package scr_pkg;
  `include "scr_defines.svh"

  typedef enum logic {SCR_IDLE, SCR_ACTIVE} scr_phase_type;

  typedef struct packed {
    scr_phase_type phase;
    logic csSync1;
    logic csSync2;
    logic csSync3;
    logic clkSync1;
    logic clkSync2;
    logic clkSync3;
    logic sdiSync1;
    logic sdiSync2;
    logic [5:0] bitCount;
    logic [`SCR_RX_W-1:0] rxShift;
    logic [`SCR_PRI_W-1:0] priShift;
    logic [`SCR_MAX_CHAN_W-1:0] secShift;
    logic priOut;
    logic priOeN;
    logic secOut;
    logic secOeN;
    logic [9:0] setup1;
    logic [8:0] setup2;
    logic [11:0] lowerLim;
    logic [11:0] upperLim;
    logic checkFail;
    logic pendValid;
    logic [2:0] pendAddr;
    logic [`SCR_MSG_W-1:0] lastSample;
  } scr_core_state_type;
endpackage

// *** src/scr_fifo.sv ***
// Small sample FIFO between the converter and the serial port
`timescale 1ns/1ns
module scr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Depth must be a power of two: pointers wrap by overflow
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic notFull;
  } scr_fifo_state_type;

  scr_fifo_state_type s_reg;
  scr_fifo_state_type s_next;
  logic push;
  logic pop;

  // Ready is a flop so the producer never sees a glitchy stall
  assign push = inValid && s_reg.notFull;
  assign pop = outReady && (s_reg.count != '0);
  assign inReady = s_reg.notFull;
  assign outValid = (s_reg.count != '0);
  assign outData = s_reg.mem[s_reg.rdPtr];

  // Pointer and occupancy update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr = s_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      s_next.rdPtr = s_reg.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
    s_next.notFull = (s_next.count != (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.notFull <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // scr_fifo

// *** src/scr_spi_crc.sv ***
// Serial port with checksum protection and the register map behind it
// Functional notes
// RULE_01 - Read and write checksums each have their own enable bit.
// RULE_02 - With read checksum on, an 8-bit checksum follows every read.
// RULE_03 - Conversion checksum covers channel A and B, sent on primary out.
// RULE_04 - Read checksum works in two-wire, one-wire and extended modes.
// RULE_05 - Host must send valid checksum with the frame enabling it.
// RULE_06 - With write checksum on, writes lacking valid checksum are dropped.
// RULE_07 - Generator polynomial is x^8+x^2+x+1, pattern 100000111.
// RULE_08 - 16-bit results join channel A first into a 32-bit message.
// RULE_09 - Top eight message bits inverted, eight zeros appended.
// RULE_10 - Checksum is the modulo-2 division remainder.
// RULE_11 - 14-bit results form a 28-bit message, same procedure.
// RULE_12 - Register read checksum covers the 16-bit register word.
// RULE_13 - Writes to read-only registers change nothing.
// RULE_14 - Writes to unimplemented addresses change nothing.
// RULE_15 - Reads of unimplemented addresses yield conversions next frame.
// RULE_16 - First setup register field layout at address 1.
// RULE_17 - Second setup register: width select bit 8, reset field 7:0.
// RULE_18 - Read-only fault flags at address 3.
// RULE_19 - Limit registers at 4 and 5, 12 bits, reset 0x800 and 0x7FF.
// RULE_20 - Write frame is 16 bits, or 24 with write checksum on.
// RULE_21 - Host puts write flag at bit 15, address 14:12, data 11:0.
// RULE_22 - Valid read request returns register data in the next frame.
// RULE_23 - Enabling write checksum without valid checksum drops the frame.
// RULE_24 - Checksum byte follows data MSB first on the same output.
`timescale 1ns/1ns
`include "scr_defines.svh"
module scr_spi_crc #(
  parameter int RESOLUTION = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic convValid,
  output logic convReady,
  input wire logic [`SCR_MSG_W-1:0] convData,
  input wire logic chanAUnder,
  input wire logic chanAOver,
  input wire logic chanBUnder,
  input wire logic chanBOver,
  input wire logic selfTestFail,
  output logic primaryDataOut,
  output logic primaryDataOeN,
  output logic secondaryOutOrFlag,
  output logic secondaryOeN,
  output logic averagingStyle,
  output logic [2:0] averagingRatio,
  output logic alertEnable,
  output logic extendedResolution,
  output logic referenceSource,
  output logic powerMode,
  output logic outputWidthSelect,
  output logic [7:0] resetCommand,
  output logic [11:0] lowerLimit,
  output logic [11:0] upperLimit,
  output logic writeCheckFail
);
  scr_pkg::scr_core_state_type s_reg;
  scr_pkg::scr_core_state_type s_next;

  logic fifoValid;
  logic fifoPop;
  logic [`SCR_MSG_W-1:0] fifoData;
  logic frameStart;
  logic frameEnd;
  logic sclkRise;
  logic sclkFall;
  logic longEnough;
  logic [15:0] wordIn;
  logic isWrite;
  logic [2:0] addrIn;
  logic crcOk;
  logic enablesCheck;
  logic needCheck;
  logic writeOk;
  logic writeBad;
  logic readReq;

  // One step of the MSB-first division by the generator
  function automatic logic [7:0] crcStep(input logic [7:0] c,
                                         input logic d);
    logic fb;
    fb = c[7] ^ d;
    return {c[6:0], 1'b0} ^ (fb ? `SCR_CRC_POLY : 8'h00); // [RULE_07]
  endfunction

  // Remainder of a left-aligned message of len bits
  function automatic logic [7:0] crcCalc(
    input logic [`SCR_MSG_W-1:0] msg,
    input logic [5:0] len);
    logic [7:0] c;
    c = `SCR_CRC_INIT; // [RULE_09]
    for (int i = 0; i < `SCR_MSG_W; i++) begin
      if (6'(i) < len) begin
        c = crcStep(c, msg[`SCR_MSG_W-1-i]); // [RULE_10]
      end
    end
    return c;
  endfunction

  // Addresses that hold a register
  function automatic logic isMapped(input logic [2:0] a);
    return (a >= `SCR_ADDR_SETUP1) && (a <= `SCR_ADDR_UPPER);
  endfunction

  // Samples wait here until a frame takes them
  scr_fifo #(
    .WIDTH(`SCR_MSG_W),
    .DEPTH(FIFO_DEPTH)
  ) sampleFifo (
    .clk(clk),
    .rst(rst),
    .inValid(convValid),
    .inReady(convReady),
    .inData(convData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // Edges of the synchronised pins; first stage is never looked at
  assign frameStart = (s_reg.phase == scr_pkg::SCR_IDLE) &&
                      !s_reg.csSync2 && s_reg.csSync3;
  assign frameEnd = (s_reg.phase == scr_pkg::SCR_ACTIVE) &&
                    s_reg.csSync2 && !s_reg.csSync3;
  assign sclkRise = s_reg.clkSync2 && !s_reg.clkSync3;
  assign sclkFall = !s_reg.clkSync2 && s_reg.clkSync3;
  assign fifoPop = frameStart && !s_reg.pendValid && fifoValid;

  // Command decode; a 24-bit frame carries its checksum last
  assign longEnough = s_reg.bitCount >= `SCR_FRAME_PLAIN; // [RULE_20]
  assign wordIn = (s_reg.bitCount >= `SCR_FRAME_CHECKED) ?
                  s_reg.rxShift[`SCR_RX_W-1:8] : s_reg.rxShift[15:0];
  assign isWrite = wordIn[`SCR_WR_BIT]; // [RULE_21]
  assign addrIn = wordIn[`SCR_ADDR_HI:`SCR_ADDR_LO];
  assign crcOk = (s_reg.bitCount >= `SCR_FRAME_CHECKED) &&
                 (crcCalc({s_reg.rxShift[`SCR_RX_W-1:8], 20'h0_0000},
                  `SCR_FRAME_PLAIN) == s_reg.rxShift[7:0]);
  assign enablesCheck = (addrIn == `SCR_ADDR_SETUP1) &&
                        wordIn[`SCR_B_CRC_W] &&
                        !s_reg.setup1[`SCR_B_CRC_W]; // [RULE_23]
  assign needCheck = s_reg.setup1[`SCR_B_CRC_W] || enablesCheck;
  assign writeOk = frameEnd && longEnough && isWrite &&
                   (!needCheck || crcOk); // [RULE_06]
  assign writeBad = frameEnd && longEnough && isWrite &&
                    needCheck && !crcOk;
  assign readReq = frameEnd && longEnough && !isWrite;

  // Whole next state of the port
  always_comb begin
    logic [5:0] w;
    logic [`SCR_MAX_CHAN_W-1:0] chanMask;
    logic [`SCR_MAX_CHAN_W-1:0] a;
    logic [`SCR_MAX_CHAN_W-1:0] b;
    logic [`SCR_MSG_W-1:0] msgA;
    logic [`SCR_MSG_W-1:0] msg;
    logic [7:0] crcPart;
    logic [15:0] rd;
    logic [`SCR_MSG_W-1:0] sample;
    logic boost;
    logic alertNow;
    w = '0;
    chanMask = '0;
    a = '0;
    b = '0;
    msgA = '0;
    msg = '0;
    crcPart = '0;
    rd = '0;
    boost = 1'b0;
    sample = fifoValid ? fifoData : s_reg.lastSample;
    alertNow = chanAUnder || chanAOver || chanBUnder || chanBOver;
    s_next = s_reg;

    // Two-flop synchronisers on every pin
    s_next.csSync1 = csN;
    s_next.csSync2 = s_reg.csSync1;
    s_next.csSync3 = s_reg.csSync2;
    s_next.clkSync1 = sclk;
    s_next.clkSync2 = s_reg.clkSync1;
    s_next.clkSync3 = s_reg.clkSync2;
    s_next.sdiSync1 = sdi;
    s_next.sdiSync2 = s_reg.sdiSync1;

    // Extra bits only count with a valid averaging ratio
    boost = s_reg.setup1[`SCR_B_EXT_RES] &&
            (s_reg.setup1[`SCR_B_RATIO_HI:`SCR_B_RATIO_LO] != 3'h0) &&
            (s_reg.setup1[`SCR_B_RATIO_HI:`SCR_B_RATIO_LO] <=
             `SCR_RATIO_VALID_MAX);
    w = boost ? 6'(RESOLUTION + `SCR_BOOST_BITS) : 6'(RESOLUTION);
    chanMask = `SCR_MAX_CHAN_W'((19'h0_0001 << w) - 19'h0_0001);
    a = sample[`SCR_MSG_W-1:`SCR_MAX_CHAN_W] & chanMask;
    b = sample[`SCR_MAX_CHAN_W-1:0] & chanMask;
    // Channel A first, B right behind it
    msgA = `SCR_MSG_W'(a) << (6'(`SCR_MSG_W) - w); // [RULE_08]
    msg = msgA | (`SCR_MSG_W'(b) << (6'(`SCR_MSG_W) - w - w)); // [RULE_11]

    // Register word, with the address nibble on top
    case (s_reg.pendAddr)
      `SCR_ADDR_SETUP1: rd = {1'b0, s_reg.pendAddr, 2'b00, s_reg.setup1};
      `SCR_ADDR_SETUP2: rd = {1'b0, s_reg.pendAddr, 3'b000, s_reg.setup2};
      `SCR_ADDR_FLAGS: begin
        rd = {1'b0, s_reg.pendAddr, 12'h000};
        rd[`SCR_B_CHK_FAIL] = s_reg.checkFail;
        rd[`SCR_B_SELF_FAIL] = selfTestFail; // [RULE_18]
        rd[`SCR_B_B_OVER] = chanBOver;
        rd[`SCR_B_B_UNDER] = chanBUnder;
        rd[`SCR_B_A_OVER] = chanAOver;
        rd[`SCR_B_A_UNDER] = chanAUnder;
      end
      `SCR_ADDR_LOWER: rd = {1'b0, s_reg.pendAddr, s_reg.lowerLim};
      `SCR_ADDR_UPPER: rd = {1'b0, s_reg.pendAddr, s_reg.upperLim};
      default: rd = '0;
    endcase

    case (s_reg.phase)
      scr_pkg::SCR_IDLE: begin
        if (frameStart) begin
          // Load the whole frame; first bit goes out at once
          s_next.phase = scr_pkg::SCR_ACTIVE;
          s_next.bitCount = '0;
          s_next.rxShift = '0;
          s_next.priOeN = 1'b0;
          s_next.secOeN = 1'b0;
          s_next.secShift = '0;
          if (s_reg.pendValid) begin
            if (s_reg.setup1[`SCR_B_CRC_R]) begin // [RULE_01]
              crcPart = crcCalc({rd, 20'h0_0000},
                                `SCR_FRAME_PLAIN); // [RULE_12]
            end
            s_next.priShift = {rd, crcPart, 20'h0_0000}; // [RULE_22]
            if (s_reg.pendAddr == `SCR_ADDR_FLAGS) begin
              s_next.checkFail = 1'b0;
            end
          end else begin
            s_next.lastSample = sample;
            if (s_reg.setup1[`SCR_B_CRC_R]) begin // [RULE_02]
              crcPart = crcCalc(msg, w + w); // [RULE_03]
            end
            if (s_reg.setup2[`SCR_B_OUT_WIDTH]) begin
              // One wire: A, B, then checksum // [RULE_04]
              s_next.priShift = {msg, 8'h00} |
                (`SCR_PRI_W'(crcPart) << (6'(`SCR_MSG_W) - w - w));
            end else begin
              // Two wires: checksum still trails A on primary
              s_next.priShift = {msgA, 8'h00} |
                (`SCR_PRI_W'(crcPart) << (6'(`SCR_MSG_W) - w)); // [RULE_24]
              s_next.secShift = b << (6'(`SCR_MAX_CHAN_W) - w);
            end
          end
          s_next.priOut = s_next.priShift[`SCR_PRI_W-1];
          s_next.priShift = s_next.priShift << 1;
          s_next.secOut = s_next.secShift[`SCR_MAX_CHAN_W-1];
          s_next.secShift = s_next.secShift << 1;
          // One-wire mode frees the second pin for alert or float
          if (s_reg.setup2[`SCR_B_OUT_WIDTH]) begin
            s_next.secOeN = !s_reg.setup1[`SCR_B_ALERT_EN];
            s_next.secOut = s_reg.setup1[`SCR_B_ALERT_EN] && alertNow;
          end
          s_next.pendValid = 1'b0;
        end
      end
      scr_pkg::SCR_ACTIVE: begin
        // Out on the rising edge, in on the falling edge
        if (sclkRise) begin
          s_next.priOut = s_reg.priShift[`SCR_PRI_W-1];
          s_next.priShift = s_reg.priShift << 1;
          if (!s_reg.setup2[`SCR_B_OUT_WIDTH]) begin
            s_next.secOut = s_reg.secShift[`SCR_MAX_CHAN_W-1];
            s_next.secShift = s_reg.secShift << 1;
          end
        end
        if (s_reg.setup2[`SCR_B_OUT_WIDTH] &&
            s_reg.setup1[`SCR_B_ALERT_EN]) begin
          s_next.secOut = alertNow;
        end
        // Bits past the checksum byte are dropped
        if (sclkFall && (s_reg.bitCount < `SCR_FRAME_CHECKED)) begin
          s_next.rxShift = {s_reg.rxShift[`SCR_RX_W-2:0], s_reg.sdiSync2};
          s_next.bitCount = s_reg.bitCount + 6'd1;
        end
        if (frameEnd) begin
          s_next.phase = scr_pkg::SCR_IDLE;
          s_next.priOeN = 1'b1;
          s_next.secOeN = 1'b1;
          if (writeOk) begin
            case (addrIn)
              `SCR_ADDR_SETUP1: s_next.setup1 = wordIn[9:0]; // [RULE_16]
              `SCR_ADDR_SETUP2: s_next.setup2 = wordIn[8:0]; // [RULE_17]
              `SCR_ADDR_LOWER: s_next.lowerLim = wordIn[11:0]; // [RULE_19]
              `SCR_ADDR_UPPER: s_next.upperLim = wordIn[11:0];
              // Flags are read-only; 0, 6, 7 are no-ops
              default: s_next.setup1 = s_reg.setup1; // [RULE_13] [RULE_14]
            endcase
          end
          // Sticky until the flags are read; a new failure wins
          if (writeBad && s_reg.setup1[`SCR_B_CRC_W]) begin
            s_next.checkFail = 1'b1; // [RULE_06]
          end
          s_next.pendValid = readReq && isMapped(addrIn); // [RULE_15]
          s_next.pendAddr = addrIn;
        end
      end
      default: s_next.phase = scr_pkg::SCR_IDLE;
    endcase
  end

  // State register; chip select and output enables idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.csSync1 <= 1'b1;
      s_reg.csSync2 <= 1'b1;
      s_reg.csSync3 <= 1'b1;
      s_reg.priOeN <= 1'b1;
      s_reg.secOeN <= 1'b1;
      s_reg.setup1 <= `SCR_RST_SETUP1;
      s_reg.setup2 <= `SCR_RST_SETUP2;
      s_reg.lowerLim <= `SCR_RST_LOWER;
      s_reg.upperLim <= `SCR_RST_UPPER;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign primaryDataOut = s_reg.priOut;
  assign primaryDataOeN = s_reg.priOeN;
  assign secondaryOutOrFlag = s_reg.secOut;
  assign secondaryOeN = s_reg.secOeN;
  assign averagingStyle = s_reg.setup1[`SCR_B_AVG_STYLE];
  assign averagingRatio = s_reg.setup1[`SCR_B_RATIO_HI:`SCR_B_RATIO_LO];
  assign alertEnable = s_reg.setup1[`SCR_B_ALERT_EN];
  assign extendedResolution = s_reg.setup1[`SCR_B_EXT_RES];
  assign referenceSource = s_reg.setup1[`SCR_B_REF_SRC];
  assign powerMode = s_reg.setup1[`SCR_B_PWR];
  assign outputWidthSelect = s_reg.setup2[`SCR_B_OUT_WIDTH];
  assign resetCommand = s_reg.setup2[`SCR_B_RSTCMD_HI:0];
  assign lowerLimit = s_reg.lowerLim;
  assign upperLimit = s_reg.upperLim;
  assign writeCheckFail = s_reg.checkFail;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence frameWrite;
    frameEnd && longEnough && isWrite;
  endsequence

  sequence frameRead;
    frameEnd && longEnough && !isWrite;
  endsequence

  AST_BAD_WRITE_HOLDS: assert property ( // [RULE_06]
    (frameWrite and (needCheck && !crcOk)) |=> $stable(s_reg.setup1) &&
      $stable(s_reg.lowerLim) && $stable(s_reg.upperLim))
    else $error("unchecked write changed a register");

  AST_FAIL_FLAG_SET: assert property ( // [RULE_06]
    (frameWrite and (s_reg.setup1[`SCR_B_CRC_W] && !crcOk))
      |=> writeCheckFail ##1 writeCheckFail)
    else $error("checksum failure flag not raised");

  AST_ENABLE_NEEDS_CHECK: assert property ( // [RULE_23]
    (frameWrite and (enablesCheck && !crcOk))
      |=> !s_reg.setup1[`SCR_B_CRC_W])
    else $error("write checksum enabled without checksum");

  AST_RO_WRITE_IGNORED: assert property ( // [RULE_13]
    (frameWrite and (addrIn == `SCR_ADDR_FLAGS)) |=> $stable(s_reg.setup1)
      && $stable(s_reg.setup2) && $stable(s_reg.lowerLim))
    else $error("read-only write altered state");

  AST_UNMAPPED_READ: assert property ( // [RULE_15]
    (frameRead and !isMapped(addrIn)) |=> !s_reg.pendValid)
    else $error("unmapped read left a pending register read");

  AST_VALID_READ: assert property ( // [RULE_22]
    (frameRead and isMapped(addrIn))
      |=> s_reg.pendValid && (s_reg.pendAddr == $past(addrIn)))
    else $error("valid read request not remembered");

  AST_FRAME_DRIVES: assert property ( // [RULE_24]
    frameStart |=> !primaryDataOeN ##1 !primaryDataOeN)
    else $error("primary output not driven in frame");

  AST_FRAME_RELEASES: assert property ( // [RULE_20]
    frameEnd |=> primaryDataOeN && secondaryOeN &&
      (s_reg.phase == scr_pkg::SCR_IDLE))
    else $error("outputs not released at frame end");

  // An all-zero register word must leave the known remainder 0xD7
  AST_POLY_STEP: assert property ( // [RULE_07]
    frameStart |-> (crcCalc(36'h0_0000_0000, `SCR_FRAME_PLAIN) == 8'hd7))
    else $error("checksum of a zero word is wrong");
endmodule // scr_spi_crc

// *** tb/scr_host_model.sv ***
// Serial host model that frames commands and collects read data
`timescale 1ns/1ns
module scr_host_model (
  output logic csN,
  output logic sclk,
  output logic sdi,
  input wire logic dataIn
);
  // Idle: frame deselected, clock parked low between frames
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One frame of n bits, MSB first; 32 ns link clock period
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = '0;
    csN = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      // Data moves mid low phase, away from the sampling fall
      #8 sdi = tx[i];
      #8 rx = {rx[22:0], dataIn};
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    // Inverse only once the last fall has been taken by the device
    #8 csN = 1'b1;
    sdi = ~sdi;
    #64;
  endtask
endmodule // scr_host_model

// *** tb/test_spi_crc_and_register_map.sv ***
// Self-checking bench for the serial checksum and register map block
`timescale 1ns/1ns
module test_spi_crc_and_register_map;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic convValid = 1'b0;
  logic aOver = 1'b0;
  logic selfFail = 1'b0;
  logic [35:0] convData = '0;
  logic csN, sclk, sdi, convReady, pOut, pOeN, sOut, sOeN;
  logic avg, alertEn, extRes, refSrc, pwr, outWidth, wrFail;
  logic [2:0] ratio;
  logic [7:0] rstCmd;
  logic [11:0] lowLim, upLim;
  logic [23:0] rx;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  // Under-range and channel B levels tied low: not exercised here
  scr_spi_crc #(.RESOLUTION(16), .FIFO_DEPTH(4)) u_dut (
    .clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .sdi(sdi),
    .convValid(convValid), .convReady(convReady), .convData(convData),
    .chanAUnder(1'b0), .chanAOver(aOver), .chanBUnder(1'b0),
    .chanBOver(1'b0), .selfTestFail(selfFail), .primaryDataOut(pOut),
    .primaryDataOeN(pOeN), .secondaryOutOrFlag(sOut),
    .secondaryOeN(sOeN), .averagingStyle(avg), .averagingRatio(ratio),
    .alertEnable(alertEn), .extendedResolution(extRes),
    .referenceSource(refSrc), .powerMode(pwr),
    .outputWidthSelect(outWidth), .resetCommand(rstCmd),
    .lowerLimit(lowLim), .upperLimit(upLim), .writeCheckFail(wrFail));

  scr_host_model u_host (.csN(csN), .sclk(sclk), .sdi(sdi),
    .dataIn(pOut));

  // Bitwise division; all-ones start equals inverting the top byte
  function automatic logic [7:0] crc8(logic [31:0] m, int len);
    logic [7:0] c;
    c = 8'hff;
    for (int i = len - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(logic [15:0] w, bit withCrc);
    if (withCrc) u_host.xfer({w, crc8({16'h0000, w}, 16)}, 24, rx);
    else u_host.xfer({8'h00, w}, 16, rx);
  endtask

  // Read request then a second frame carrying the register word
  task automatic rdreg(logic [2:0] a, logic [15:0] exp, bit withCrc);
    cmd({1'b0, a, 12'h000}, 1'b0);
    u_host.xfer(24'h00_0000, withCrc ? 24 : 16, rx);
    if (withCrc) chk("register read", {exp, crc8({16'h0, exp}, 16)}, rx);
    else chk("register read", {8'h00, exp}, {8'h00, rx[15:0]});
  endtask

  task automatic test_reset_values;
    chk("limits", {12'h800, 12'h7ff}, {lowLim, upLim});
    chk("outputWidthSelect", 24'h0, {23'h0, outWidth});
    rdreg(3'h4, 16'h4800, 1'b0);
    rdreg(3'h2, 16'h2000, 1'b0);
  endtask

  task automatic test_setup_and_read_crc;
    cmd(16'h9353, 1'b0);
    chk("setup fields", 24'h0000d3,
      {16'h0, avg, ratio, alertEn, extRes, refSrc, pwr});
    rdreg(3'h1, 16'h1353, 1'b1);
    rdreg(3'h5, 16'h57ff, 1'b1);
  endtask

  task automatic test_no_op_access;
    cmd(16'hbfff, 1'b0);
    cmd(16'hffff, 1'b0);
    chk("limits kept", {12'h800, 12'h7ff}, {lowLim, upLim});
    aOver = 1'b1;
    selfFail = 1'b1;
    rdreg(3'h3, 16'h3102, 1'b1);
    selfFail = 1'b0;
    cmd(16'h6000, 1'b0);
    // Offer one sample so the next conversion frame has known data
    @(negedge clk);
    convValid = 1'b1;
    convData = {2'b00, 16'ha5c3, 2'b00, 16'h3c5a};
    @(negedge clk);
    convValid = 1'b0;
    u_host.xfer(24'h00_0000, 24, rx);
    chk("conversion", {16'ha5c3, crc8(32'ha5c3_3c5a, 32)}, rx);
  endtask

  // One-wire output with the alert level on the second pin
  task automatic test_one_wire_alert;
    cmd(16'ha1a5, 1'b0);
    chk("setup2 fields", 24'h0001a5, {15'h0, outWidth, rstCmd});
    cmd(16'h935b, 1'b0);
    fork
      u_host.xfer(24'h00_0000, 24, rx);
      begin
        #200;
        chk("alert pin", 24'h000001, {22'h0, sOeN, sOut});
      end
    join
    chk("one-wire conversion", {16'ha5c3, 8'h3c}, rx);
    aOver = 1'b0;
    cmd(16'ha000, 1'b0);
    cmd(16'h9353, 1'b0);
  endtask

  task automatic test_write_crc;
    cmd(16'h9373, 1'b0);
    rdreg(3'h1, 16'h1353, 1'b1);
    cmd(16'h9373, 1'b1);
    rdreg(3'h1, 16'h1373, 1'b1);
    cmd(16'hc123, 1'b0);
    chk("unchecked write", 24'h800001, {lowLim, 11'h0, wrFail});
    cmd(16'h9353, 1'b0);
    rdreg(3'h1, 16'h1373, 1'b1);
    cmd(16'hc123, 1'b1);
    chk("checked write", 24'h000123, {12'h0, lowLim});
    rdreg(3'h3, 16'h3200, 1'b1);
    chk("flag cleared", 24'h000000, {23'h0, wrFail});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Whole run needs about 5700 cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    test_reset_values();
    test_setup_and_read_crc();
    test_no_op_access();
    test_one_wire_alert();
    test_write_crc();
    end_of_test();
  end
endmodule // test_spi_crc_and_register_map
